// ---- common/sslo_pkg.sv ----
// Package for the soft strap latch and override block.
// Assumes a single 200 MHz clock domain and an APB register port.
package sslo_pkg;

  // Register byte offsets
  localparam logic [7:0] SSLO_CTRL_OFS = 8'h00;
  localparam logic [7:0] SSLO_LOAD_OFS = 8'h04;
  localparam logic [7:0] SSLO_LATCHED_OFS = 8'h08;
  localparam logic [7:0] SSLO_EFFECTIVE_OFS = 8'h0c;
  localparam logic [7:0] SSLO_STATUS_OFS = 8'h10;

  // Control register fields
  localparam int SSLO_CTRL_DIGRST_BIT = 0;
  localparam int SSLO_CTRL_RELOAD_BIT = 1;
  localparam int SSLO_CTRL_XOVR_BIT = 2;

  // Field positions of the packed strap word
  localparam int SSLO_LEDEN_LSB = 0;
  localparam int SSLO_LEDFUN_LSB = 8;
  localparam int SSLO_AMDIX_BIT = 10;
  localparam int SSLO_MMDIX_BIT = 11;
  localparam int SSLO_ANEG_BIT = 12;
  localparam int SSLO_STRAP_W = 13;

  // Tie-off defaults for straps without a pin
  localparam logic [1:0] SSLO_LEDFUN_TIE = 2'h0;
  localparam logic SSLO_MMDIX_TIE = 1'b0;

  // Loader handshake timeout, in cycles
  localparam int SSLO_LOAD_WAIT = 16;

  // Soft strap set
  typedef struct packed {
    logic aneg;
    logic manual_mdix;
    logic auto_mdix;
    logic [1:0] led_function;
    logic [7:0] led_enable;
  } sslo_strap_t;

  // Derived configuration for the port and LED logic
  typedef struct packed {
    logic [7:0] led_enable_bits;
    logic [1:0] led_function_bits;
    logic auto_crossover_en;
    logic mdix_select;
    logic autonegotiate_enable_bit;
    logic speed_select_low_bit;
    logic duplex_select_bit;
    logic advert_10fd;
    logic advert_10hd;
    logic [2:0] special_mode;
  } sslo_cfg_t;

  typedef enum logic [2:0] {
    SSLO_IDLE = 3'b001,
    SSLO_LOAD = 3'b010,
    SSLO_DONE = 3'b100
  } sslo_state_t;

endpackage : sslo_pkg

// ---- hw/sslo_top.sv ----
// Soft strap capture, loader override and configuration output.
// Assumes all inputs synchronous to ref_clk_i; the loader presents
// its memory presence and strap values during a load run.
//
// Contract
// - Capture straps at power-on or pin reset
// - Loader values replace captured straps when present
// - Effective straps drive configuration and register defaults
// - Pinless straps take fixed tie-off values
// - Absent memory on reload restores captured straps
// - Digital reset or reload never resamples pins
// - LED enable one selects LED, zero GPIO; code drives gpio_mode_n_o low when any enable bit is one
// - One pin defaults eight LED bits individually; code copies the one pin to all eight
// - LED function defaults 00, bitwise from strap
// - Clear override: auto-crossover strap sets behaviour
// - Set override ignores auto-crossover strap
// - Manual strap picks MDI or MDIX, default zero
// - Auto-negotiation strap sets enable bit default
// - Auto-negotiation strap feeds speed, duplex, advert, mode
// - Loader starts after digital reset, no recapture
// - Only soft straps are loader overridable
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module sslo_top (
  // Clock and resets
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic external_pin_reset_n_i,
  // Strap pins
  input wire logic led_enable_bits_pin_i,
  input wire logic auto_mdix_pin_i,
  input wire logic aneg_pin_i,
  // Loader side
  output logic loader_start_o,
  input wire logic loader_present_i,
  input wire logic loader_valid_i,
  input wire logic [12:0] loader_data_i,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Configuration out
  output sslo_pkg::sslo_cfg_t cfg_o,
  output logic gpio_mode_n_o
);

  // Power-on and pin reset share one capture path
  logic capture_rst;
  assign capture_rst = !reset_n_i || !external_pin_reset_n_i;

  sslo_pkg::sslo_strap_t latched_reg, latched_next;
  sslo_pkg::sslo_strap_t eff_reg, eff_next;
  sslo_pkg::sslo_state_t state_reg, state_next;
  logic capture_pend_reg, capture_pend_next;
  logic xovr_reg, xovr_next;
  logic loaded_reg, loaded_next;
  logic [4:0] wait_reg, wait_next;
  logic [31:0] prdata_reg, prdata_next;
  logic slverr_reg, slverr_next;

  logic apb_wr;
  logic apb_rd;
  logic start_req;
  sslo_pkg::sslo_strap_t pin_sample;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;

  // Pins with tie-offs for straps that have none
  always_comb
  begin
    pin_sample = '0;
    pin_sample.led_enable = {8{led_enable_bits_pin_i}};
    pin_sample.led_function = sslo_pkg::SSLO_LEDFUN_TIE;
    pin_sample.auto_mdix = auto_mdix_pin_i;
    pin_sample.manual_mdix = sslo_pkg::SSLO_MMDIX_TIE;
    pin_sample.aneg = aneg_pin_i;
  end

  // Reload and digital reset requests
  always_comb
  begin
    start_req = apb_wr && paddr == sslo_pkg::SSLO_CTRL_OFS &&
      (pwdata[sslo_pkg::SSLO_CTRL_DIGRST_BIT] || pwdata[sslo_pkg::SSLO_CTRL_RELOAD_BIT]);
  end

  // Capture, copy and loader sequencing
  always_comb
  begin
    latched_next = latched_reg;
    eff_next = eff_reg;
    state_next = state_reg;
    capture_pend_next = 1'b0;
    loaded_next = loaded_reg;
    wait_next = wait_reg;
    xovr_next = xovr_reg;
    loader_start_o = 1'b0;
    // Pins are sampled on the first edge after reset release only
    if (capture_pend_reg)
    begin
      latched_next = pin_sample;
      eff_next = pin_sample;
      state_next = sslo_pkg::SSLO_LOAD; // Initial load after capture
      wait_next = '0;
    end
    else
    begin
      if (apb_wr && paddr == sslo_pkg::SSLO_CTRL_OFS)
        xovr_next = pwdata[sslo_pkg::SSLO_CTRL_XOVR_BIT];
      case (state_reg)
        sslo_pkg::SSLO_IDLE:
        begin
          if (start_req)
          begin
            eff_next = latched_reg;
            state_next = sslo_pkg::SSLO_LOAD;
            wait_next = '0;
          end
        end
        sslo_pkg::SSLO_LOAD:
        begin
          loader_start_o = 1'b1;
          wait_next = wait_reg + 5'h01;
          // Only the soft strap word is taken from the loader
          if (loader_present_i && loader_valid_i)
          begin
            eff_next = sslo_pkg::sslo_strap_t'(loader_data_i);
            loaded_next = 1'b1;
            state_next = sslo_pkg::SSLO_DONE;
          end
          else if (!loader_present_i || wait_reg == 5'(sslo_pkg::SSLO_LOAD_WAIT))
          begin
            loaded_next = 1'b0; // Effective copy stays at latched value
            state_next = sslo_pkg::SSLO_DONE;
          end
        end
        sslo_pkg::SSLO_DONE:
          state_next = sslo_pkg::SSLO_IDLE;
        default:
          state_next = sslo_pkg::SSLO_IDLE;
      endcase
    end
  end

  // State registers; capture is held off until the reset releases
  always_ff @(posedge ref_clk_i)
  begin
    if (capture_rst)
    begin
      latched_reg <= '0;
      eff_reg <= '0;
      state_reg <= sslo_pkg::SSLO_IDLE;
      capture_pend_reg <= 1'b1;
      loaded_reg <= 1'b0;
      wait_reg <= '0;
      xovr_reg <= 1'b0;
    end
    else
    begin
      latched_reg <= latched_next;
      eff_reg <= eff_next;
      state_reg <= state_next;
      capture_pend_reg <= capture_pend_next;
      loaded_reg <= loaded_next;
      wait_reg <= wait_next;
      xovr_reg <= xovr_next;
    end
  end

  // Read mux; unmapped addresses answer with an error
  always_comb
  begin
    prdata_next = '0;
    slverr_next = 1'b0;
    if (paddr == sslo_pkg::SSLO_CTRL_OFS)
      prdata_next[sslo_pkg::SSLO_CTRL_XOVR_BIT] = xovr_reg;
    else if (paddr == sslo_pkg::SSLO_LOAD_OFS)
      prdata_next = '0;
    else if (paddr == sslo_pkg::SSLO_LATCHED_OFS)
      prdata_next[12:0] = latched_reg;
    else if (paddr == sslo_pkg::SSLO_EFFECTIVE_OFS)
      prdata_next[12:0] = eff_reg;
    else if (paddr == sslo_pkg::SSLO_STATUS_OFS)
      prdata_next[3:0] = {loaded_reg, state_reg};
    else
      slverr_next = 1'b1;
    if (!(psel && !penable))
    begin
      prdata_next = prdata_reg;
      slverr_next = slverr_reg;
    end
  end

  // Read data captured in setup, presented in access
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      prdata_reg <= '0;
      slverr_reg <= 1'b0;
    end
    else
    begin
      prdata_reg <= prdata_next;
      slverr_reg <= slverr_next;
    end
  end

  assign pready = 1'b1;
  assign prdata = apb_rd ? prdata_reg : 32'h0000_0000;
  assign pslverr = psel && penable && slverr_reg;

  // Derived configuration, registered
  sslo_pkg::sslo_cfg_t cfg_reg, cfg_next;
  always_comb
  begin
    cfg_next.led_enable_bits = eff_reg.led_enable;
    cfg_next.led_function_bits = eff_reg.led_function;
    // Override bit set hides the strap from the PHY
    cfg_next.auto_crossover_en = !xovr_reg && eff_reg.auto_mdix;
    cfg_next.mdix_select = (!xovr_reg && !eff_reg.auto_mdix) ?
      eff_reg.manual_mdix : 1'b0;
    cfg_next.autonegotiate_enable_bit = eff_reg.aneg;
    cfg_next.speed_select_low_bit = eff_reg.aneg;
    cfg_next.duplex_select_bit = eff_reg.aneg;
    cfg_next.advert_10fd = eff_reg.aneg;
    cfg_next.advert_10hd = eff_reg.aneg;
    cfg_next.special_mode = {3{eff_reg.aneg}};
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (capture_rst)
      cfg_reg <= '0;
    else
      cfg_reg <= cfg_next;
  end

  assign cfg_o = cfg_reg;
  assign gpio_mode_n_o = ~|cfg_reg.led_enable_bits;

  // Checks
  recapture_pins_a: assert property (@(posedge ref_clk_i) disable iff (capture_rst)
    capture_pend_reg |=> latched_reg == $past(pin_sample))
    else $error("straps not captured after reset release");
  latched_hold_a: assert property (@(posedge ref_clk_i) disable iff (capture_rst)
    !capture_pend_reg |=> $stable(latched_reg))
    else $error("captured straps changed without reset");
  revert_copy_a: assert property (@(posedge ref_clk_i) disable iff (capture_rst)
    (state_reg == sslo_pkg::SSLO_IDLE && start_req && !capture_pend_reg)
    |=> eff_reg == latched_reg && state_reg == sslo_pkg::SSLO_LOAD)
    else $error("effective straps not restored on reload");
  loader_apply_a: assert property (@(posedge ref_clk_i) disable iff (capture_rst)
    (state_reg == sslo_pkg::SSLO_LOAD && loader_present_i && loader_valid_i
     && !capture_pend_reg) |=> eff_reg == $past(loader_data_i))
    else $error("loader value not applied");
  tie_off_a: assert property (@(posedge ref_clk_i) disable iff (capture_rst)
    capture_pend_reg |=> latched_reg.led_function == 2'h0 && !latched_reg.manual_mdix)
    else $error("tie-off straps wrong");
  xover_ignore_a: assert property (@(posedge ref_clk_i) disable iff (capture_rst)
    xovr_reg ##1 xovr_reg |-> !cfg_reg.auto_crossover_en)
    else $error("auto-crossover strap not ignored");
  aneg_fanout_a: assert property (@(posedge ref_clk_i) disable iff (capture_rst)
    ##1 cfg_reg.special_mode == {3{$past(eff_reg.aneg)}}
    && cfg_reg.duplex_select_bit == $past(eff_reg.aneg))
    else $error("auto-negotiation defaults wrong");
  led_map_a: assert property (@(posedge ref_clk_i) disable iff (capture_rst)
    ##1 cfg_reg.led_enable_bits == $past(eff_reg.led_enable))
    else $error("LED enable bits wrong");
  load_bound_a: assert property (@(posedge ref_clk_i) disable iff (capture_rst)
    state_reg == sslo_pkg::SSLO_LOAD |-> ##[1:18] state_reg != sslo_pkg::SSLO_LOAD)
    else $error("loader run never ended");

endmodule : sslo_top

`default_nettype wire

// ---- verif/sslo_loader_model.sv ----
// Behavioural configuration memory loader facing the strap block.
// Assumes the bench sets presence, answer delay and word per run.
`timescale 1ns/100ps
`default_nettype none

module sslo_loader_model (
  // Clock and run request
  input wire logic clk_i,
  input wire logic start_i,
  // Bench controls
  input wire logic present_cfg_i,
  input wire logic [7:0] delay_cfg_i,
  input wire logic [12:0] data_cfg_i,
  // Loader outputs
  output logic present_o,
  output logic valid_o,
  output logic [12:0] data_o
);
  logic [7:0] cnt;
  logic [12:0] last;

  assign present_o = present_cfg_i;
  initial
  begin
    valid_o = 1'b0;
    data_o = 13'h1fff;
    cnt = 8'h00;
    last = 13'h0000;
  end

  // One word a run; off the pulse the data shows the inverse of the last word
  always @(posedge clk_i)
  begin
    valid_o <= 1'b0;
    data_o <= ~last;
    if (start_i && present_cfg_i && !valid_o)
    begin
      if (cnt == delay_cfg_i)
      begin
        valid_o <= 1'b1;
        data_o <= data_cfg_i;
        last <= data_cfg_i;
        cnt <= 8'h00;
      end
      else
        cnt <= cnt + 8'h01;
    end
    else
      cnt <= 8'h00;
  end
endmodule : sslo_loader_model

`default_nettype wire

// ---- verif/sslo_top_tb_top.sv ----
// Self-checking bench of the soft strap latch block.
// Assumes zero-wait APB and the loader model on the far side.
`timescale 1ns/100ps
`default_nettype none

module sslo_top_tb_top;
  logic clk, rst_n, pin_rst_n, led_p, mdix_p, aneg_p, psel, penable, pwrite;
  logic pready, pslverr, start, pres, vld, gpio_n, mpres, err;
  logic [7:0] paddr, dly;
  logic [31:0] pwdata, prdata, rd, seed, rnd;
  logic [12:0] ldat, mdat, lat;
  sslo_pkg::sslo_cfg_t cfg;
  int fail_count, n_compared;

  sslo_top dut (.ref_clk_i(clk), .reset_n_i(rst_n), .external_pin_reset_n_i(pin_rst_n),
    .led_enable_bits_pin_i(led_p), .auto_mdix_pin_i(mdix_p), .aneg_pin_i(aneg_p),
    .loader_start_o(start), .loader_present_i(pres), .loader_valid_i(vld),
    .loader_data_i(ldat), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg_o(cfg), .gpio_mode_n_o(gpio_n));
  sslo_loader_model mdl (.clk_i(clk), .start_i(start), .present_cfg_i(mpres),
    .delay_cfg_i(dly), .data_cfg_i(mdat), .present_o(pres), .valid_o(vld),
    .data_o(ldat));

  // Free-running 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Captured word: pinless straps take their tie-off values
  function automatic logic [12:0] strap(logic l, logic a, logic n);
    return {n, sslo_pkg::SSLO_MMDIX_TIE, a, sslo_pkg::SSLO_LEDFUN_TIE, {8{l}}};
  endfunction : strap

  function automatic sslo_pkg::sslo_cfg_t exp_cfg(logic [12:0] s);
    sslo_pkg::sslo_cfg_t c;
    c.led_enable_bits = s[7:0];
    c.led_function_bits = s[9:8];
    c.auto_crossover_en = s[10];
    c.mdix_select = s[11] & ~s[10];
    {c.autonegotiate_enable_bit, c.speed_select_low_bit, c.duplex_select_bit} = {3{s[12]}};
    {c.advert_10fd, c.advert_10hd, c.special_mode} = {5{s[12]}};
    return c;
  endfunction : exp_cfg

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Setup then access phase, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  // A loader run must start and finish in bounded time
  task automatic wait_run();
    int k;
    k = 0;
    while (start !== 1'b1 && k < 40)
    begin
      @(posedge clk);
      k++;
    end
    chk(32'(start), 32'h1);
    while (start === 1'b1 && k < 80)
    begin
      @(posedge clk);
      k++;
    end
    chk(32'(start), 32'h0);
    repeat (3) @(posedge clk);
  endtask : wait_run

  task automatic check_all(input logic [12:0] s);
    apb(1'b0, sslo_pkg::SSLO_LATCHED_OFS, 32'h0);
    chk(rd, 32'(lat));
    apb(1'b0, sslo_pkg::SSLO_EFFECTIVE_OFS, 32'h0);
    chk(rd, 32'(s));
    chk(32'(cfg), 32'(exp_cfg(s)));
    chk(32'(gpio_n), 32'(~|s[7:0]));
  endtask : check_all

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  // Watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    seed = 32'h7bcd0bff;
    {rst_n, pin_rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    pin_rst_n = 1'b1;
    {mpres, dly, mdat, fail_count, n_compared} = '0;
    rnd = xs();
    {led_p, mdix_p, aneg_p} = rnd[2:0];
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    lat = strap(led_p, mdix_p, aneg_p);
    wait_run();
    check_all(lat);
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(err), 32'h1);
    $display("capture test done");
    // Loader words replace the effective copy only
    for (int i = 0; i < 5; i++)
    begin
      // Loader controls change on the edge by NBA to avoid races
      rnd = xs();
      mdat <= (i == 0) ? 13'h1fff : (i == 1) ? 13'h0000 : rnd[12:0];
      dly <= 8'(xs() % 8);
      mpres <= 1'b1;
      apb(1'b1, sslo_pkg::SSLO_CTRL_OFS, 32'h2);
      wait_run();
      check_all(mdat);
    end
    $display("override test done");
    // Pins move, memory gone: revert to the old capture
    {led_p, mdix_p, aneg_p} <= ~{led_p, mdix_p, aneg_p};
    mpres <= 1'b0;
    apb(1'b1, sslo_pkg::SSLO_CTRL_OFS, 32'h1);
    wait_run();
    check_all(lat);
    $display("revert test done");
    // Manual crossover, then override masks the straps
    mdat <= 13'h0800;
    mpres <= 1'b1;
    apb(1'b1, sslo_pkg::SSLO_CTRL_OFS, 32'h2);
    wait_run();
    chk(32'(cfg.mdix_select), 32'h1);
    apb(1'b1, sslo_pkg::SSLO_CTRL_OFS, 32'h4);
    repeat (3) @(posedge clk);
    chk(32'(cfg.mdix_select), 32'h0);
    // Override reads back alone; request bits self-clear
    apb(1'b0, sslo_pkg::SSLO_CTRL_OFS, 32'h0);
    chk(rd, 32'h4);
    // Auto strap set but masked while the override holds
    mdat <= 13'h0400;
    apb(1'b1, sslo_pkg::SSLO_CTRL_OFS, 32'h6);
    wait_run();
    chk(32'(cfg.auto_crossover_en), 32'h0);
    apb(1'b1, sslo_pkg::SSLO_CTRL_OFS, 32'h2);
    wait_run();
    chk(32'(cfg.auto_crossover_en), 32'h1);
    $display("crossover test done");
    // Pin reset recaptures the present levels
    mpres <= 1'b0;
    pin_rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    pin_rst_n <= 1'b1;
    lat = strap(led_p, mdix_p, aneg_p);
    wait_run();
    check_all(lat);
    $display("recapture test done");
    report_and_stop();
  end
endmodule : sslo_top_tb_top

`default_nettype wire
